// ===== verilog/mss_pkg.sv
// Shared constants, register map and carrier types of the mass scan sequencer.
// Assumes a 10 MHz system clock and an AXI4-Lite master with 32-bit data.
//
// Operation
// - Histogram sweep measures one current per integer mass, initial to final inclusive.
// - Each current is a 32-bit float word, sent as four bytes, low byte first.
// - Any command during a scan aborts it, stops sending, empties transmit buffer.
// - Before each scan with automatic offset on, check detector offset, adding a short delay.
// - Every scan ends with one total pressure word, zero when disabled.
// - Point-count query returns final minus initial plus one, pressure word excluded.
// - Final mass is 1 to maximum and not below initial mass.
// - Initial mass is 1 to maximum and not above final mass.
// - One mass pair serves all histogram scans; first and last points sit there; readable.
// - Multiple-mass run measures list in order, repeats kept, one word each.
// - Each listed mass takes 13 readings 0.05 amu apart; largest is reported.
// - Detector and rate are latched at trigger; later changes do not apply.
// - Reading duration follows rate only; ion readings start after a settling wait, which follows any offset check.
// - Multiplier voltage setting selects collector cup or multiplier detector.
// - Automatic offset setting takes 0 or 1, and reads back 0 or 1.
// - Without any offset since power-on, first scan measures offset regardless.
// - After an abort, the aborting command is still executed.

`default_nettype none

package mss_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INIT = 8'h08;
  localparam logic [7:0] ADDR_FINAL = 8'h0C;
  localparam logic [7:0] ADDR_POINTS = 8'h10;
  localparam logic [7:0] ADDR_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_LIST = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OP_LSB = 0;
  localparam int ARG_LSB = 16;
  localparam int IDX_LSB = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REJ_BIT = 1;
  localparam int ST_OFS_BIT = 2;
  localparam int ST_TX_BIT = 3;
  localparam int CF_AUTO_BIT = 0;
  localparam int CF_DET_BIT = 1;
  localparam int CF_TP_BIT = 2;
  localparam int CF_RATE_LSB = 8;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_HIST = 4'h1;
  localparam logic [3:0] OP_MULTI = 4'h2;
  localparam logic [3:0] OP_SET_INIT = 4'h3;
  localparam logic [3:0] OP_SET_FINAL = 4'h4;
  localparam logic [3:0] OP_SET_AUTO = 4'h5;
  localparam logic [3:0] OP_SET_DET = 4'h6;
  localparam logic [3:0] OP_SET_TP = 4'h7;
  localparam logic [3:0] OP_SET_RATE = 4'h8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [8:0] INIT_RST = 9'h001;
  localparam logic [8:0] FINAL_RST = 9'h041;
  localparam logic [7:0] RATE_RST = 8'h10;
  localparam logic AUTO_RST = 1'b1;
  localparam logic TP_RST = 1'b1;

  // ----------------------------------------------------------------
  // Timing and miniscan geometry
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS = 20000;
  localparam int SETTLE_CYC = (SETTLE_NS / CLK_PERIOD_NS < 1) ? 1 : SETTLE_NS / CLK_PERIOD_NS;
  localparam logic [4:0] MINI_LAST = 5'h0C;
  localparam logic [15:0] MINI_HALF = 16'h0006;
  localparam logic [15:0] STEPS_PER_AMU = 16'h0014;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_ION = 2'b00,
    KIND_OFFSET = 2'b01,
    KIND_PRESSURE = 2'b10
  } mss_kind_type;

  // Mass position is in 0.05 amu steps
  typedef struct packed {
    mss_kind_type kind;
    logic [15:0] massStep;
    logic multiplier;
    logic [7:0] rate;
  } mss_meas_req_type;

endpackage

`default_nettype wire

// ===== verilog/mss_byte_serializer.sv
// Four-byte word to byte stream, low byte first, with flush.
// Assumes the sink samples txData while txValid and txReady are both high.

`default_nettype none

module mss_byte_serializer
  import mss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic flush,
  input wire logic wordValid,
  input wire logic [31:0] wordData,
  output logic wordReady,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady
);

  logic [31:0] shift_ff;
  logic [2:0] left_ff;
  logic valid_ff;

  assign wordReady = (left_ff == 3'h0) && !flush;
  assign txData = shift_ff[7:0];
  assign txValid = valid_ff;

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= 32'h00000000;
      left_ff <= 3'h0;
      valid_ff <= 1'b0;
    end else if (ce) begin
      if (flush) begin
        left_ff <= 3'h0;
        valid_ff <= 1'b0;
      end else if (wordValid && wordReady) begin
        shift_ff <= wordData;
        left_ff <= 3'h4;
        valid_ff <= 1'b1;
      end else if (valid_ff && txReady) begin
        shift_ff <= {8'h00, shift_ff[31:8]};
        left_ff <= left_ff - 3'h1;
        valid_ff <= (left_ff != 3'h1);
      end
    end
  end

endmodule

`default_nettype wire

// ===== verilog/mass_scan_sequencer.sv
// Histogram and peak-locked multiple-mass scan sequencer with AXI4-Lite control.
// Assumes a measurement engine on the same clock that answers each request
// with a one-cycle measDone pulse and a float result.

`default_nettype none

module mass_scan_sequencer
  import mss_pkg::*;
#(
  parameter int MAX_MASS = 120,
  parameter int LIST_DEPTH = 20,
  parameter int SETTLE_CYCLES = SETTLE_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output mss_meas_req_type measReq,
  output logic measReqValid,
  input wire logic measDone,
  input wire logic [31:0] measData,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OFFSET = 3'b001,
    S_SETTLE = 3'b010,
    S_POINT = 3'b011,
    S_WAIT = 3'b100,
    S_SEND = 3'b101,
    S_PRESS = 3'b110
  } mss_state_type;

  localparam logic [8:0] MAX_M = 9'(MAX_MASS);
  localparam logic [4:0] LIST_N = 5'(LIST_DEPTH);
  localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_CYCLES);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic massOk(input logic [8:0] m);
    massOk = (m >= 9'h001) && (m <= MAX_M);
  endfunction

  // Signed-magnitude compare of two single precision values
  function automatic logic floatGt(input logic [31:0] a, input logic [31:0] b);
    if (a[31] != b[31]) begin
      floatGt = !a[31];
    end else if (!a[31]) begin
      floatGt = a[30:0] > b[30:0];
    end else begin
      floatGt = a[30:0] < b[30:0];
    end
  endfunction

  function automatic logic [31:0] strobeMask(input logic [31:0] d, input logic [3:0] s);
    strobeMask = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic awReady_ff, wReady_ff, awHeld_ff, wHeld_ff, bValid_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [1:0] bResp_ff;
  logic arReady_ff, rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0] rResp_ff;
  logic [8:0] init_ff, final_ff;
  logic autoOfs_ff, multiplier_ff, tpEnable_ff, rejected_ff, offsetDone_ff;
  logic [7:0] rate_ff;
  logic [8:0] list_ff [LIST_DEPTH];
  logic [4:0] listCount_ff;
  mss_state_type state_ff;
  logic isMulti_ff, lastWord_ff, detLatch_ff;
  logic [7:0] rateLatch_ff;
  logic [8:0] baseMass_ff, pointIdx_ff, lastIdx_ff;
  logic [4:0] sub_ff;
  logic [31:0] peak_ff, word_ff;
  logic [15:0] settle_ff;
  mss_meas_req_type measReq_ff;
  logic measValid_ff;

  logic wrFire, cmdFire, scanStart, abortScan, listOk, wordReady, badCmd, mapped;
  logic [31:0] wd;
  logic [3:0] op;
  logic [8:0] arg, curMass;
  logic [31:0] best;

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
  assign measReq = measReq_ff;
  assign measReqValid = measValid_ff;

  assign wrFire = awHeld_ff && wHeld_ff && !bValid_ff;
  assign wd = wData_ff;
  assign op = wd[OP_LSB +: 4];
  assign arg = wd[ARG_LSB +: 9];
  assign cmdFire = wrFire && (awAddr_ff == ADDR_CMD);
  assign mapped = (awAddr_ff == ADDR_CMD) || (awAddr_ff == ADDR_STATUS) ||
                  (awAddr_ff == ADDR_LIST);

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awReady_ff <= 1'b1;
      wReady_ff <= 1'b1;
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      bValid_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h00000000;
      bResp_ff <= 2'h0;
    end else if (ce) begin
      if (s_axi_awvalid && awReady_ff) begin
        awAddr_ff <= {s_axi_awaddr[7:2], 2'h0};
        awHeld_ff <= 1'b1;
        awReady_ff <= 1'b0;
      end
      if (s_axi_wvalid && wReady_ff) begin
        wData_ff <= strobeMask(s_axi_wdata, s_axi_wstrb);
        wHeld_ff <= 1'b1;
        wReady_ff <= 1'b0;
      end
      if (wrFire) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff <= mapped ? 2'h0 : 2'h2;
      end
      if (bValid_ff && s_axi_bready) begin
        bValid_ff <= 1'b0;
        awReady_ff <= 1'b1;
        wReady_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arReady_ff <= 1'b1;
      rValid_ff <= 1'b0;
      rData_ff <= 32'h00000000;
      rResp_ff <= 2'h0;
    end else if (ce) begin
      if (s_axi_arvalid && arReady_ff) begin
        arReady_ff <= 1'b0;
        rValid_ff <= 1'b1;
        rResp_ff <= 2'h0;
        rData_ff <= 32'h00000000;
        case ({s_axi_araddr[7:2], 2'h0})
          ADDR_CMD, ADDR_LIST: rData_ff <= 32'h00000000;
          ADDR_STATUS: begin
            rData_ff[ST_BUSY_BIT] <= (state_ff != S_IDLE);
            rData_ff[ST_REJ_BIT] <= rejected_ff;
            rData_ff[ST_OFS_BIT] <= offsetDone_ff;
            rData_ff[ST_TX_BIT] <= txValid;
          end
          ADDR_INIT: rData_ff <= {23'h000000, init_ff};
          ADDR_FINAL: rData_ff <= {23'h000000, final_ff};
          ADDR_POINTS: rData_ff <= {23'h000000, final_ff - init_ff + 9'h001};
          ADDR_CONFIG: begin
            rData_ff[CF_AUTO_BIT] <= autoOfs_ff;
            rData_ff[CF_DET_BIT] <= multiplier_ff;
            rData_ff[CF_TP_BIT] <= tpEnable_ff;
            rData_ff[CF_RATE_LSB +: 8] <= rate_ff;
          end
          default: rResp_ff <= 2'h2;
        endcase
      end
      if (rValid_ff && s_axi_rready) begin
        rValid_ff <= 1'b0;
        arReady_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    listOk = (listCount_ff >= 5'h01) && (listCount_ff <= LIST_N);
    for (int i = 0; i < LIST_DEPTH; i++) begin
      if (5'(i) < listCount_ff && !massOk(list_ff[i])) begin
        listOk = 1'b0;
      end
    end
  end

  always_comb begin
    badCmd = 1'b0;
    case (op)
      OP_HIST: badCmd = 1'b0;
      OP_MULTI: badCmd = !listOk;
      OP_SET_INIT: badCmd = !massOk(arg) || (arg > final_ff);
      OP_SET_FINAL: badCmd = !massOk(arg) || (arg < init_ff);
      OP_SET_AUTO, OP_SET_TP: badCmd = (arg > 9'h001);
      OP_SET_DET, OP_SET_RATE: badCmd = 1'b0;
      default: badCmd = 1'b1;
    endcase
  end

  assign abortScan = cmdFire && (state_ff != S_IDLE || txValid);
  // Aborting command still runs in the same cycle
  assign scanStart = cmdFire && !badCmd && ((op == OP_HIST) || (op == OP_MULTI));

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_ff <= INIT_RST;
      final_ff <= FINAL_RST;
      autoOfs_ff <= AUTO_RST;
      multiplier_ff <= 1'b0;
      tpEnable_ff <= TP_RST;
      rate_ff <= RATE_RST;
      listCount_ff <= 5'h00;
    end else if (ce && cmdFire && !badCmd) begin
      case (op)
        OP_SET_INIT: init_ff <= arg;
        OP_SET_FINAL: final_ff <= arg;
        OP_SET_AUTO: autoOfs_ff <= arg[0];
        OP_SET_DET: multiplier_ff <= (arg != 9'h000);
        OP_SET_TP: tpEnable_ff <= arg[0];
        OP_SET_RATE: rate_ff <= arg[7:0];
        default: listCount_ff <= listCount_ff;
      endcase
    end else if (ce && wrFire && awAddr_ff == ADDR_LIST) begin
      if (wd[IDX_LSB +: 5] == 5'h1F) begin
        listCount_ff <= arg[4:0];
      end
    end
  end

  // Index 31 sets the list length; indexes below LIST_N load valid entries
  always_ff @(posedge sys_clk) begin
    if (ce && wrFire && awAddr_ff == ADDR_LIST && wd[IDX_LSB +: 5] < LIST_N && massOk(arg)) begin
      list_ff[wd[IDX_LSB +: 5]] <= arg;
    end
  end

  // Set wins over the write-one clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rejected_ff <= 1'b0;
    end else if (ce) begin
      if ((cmdFire && badCmd) || (wrFire && awAddr_ff == ADDR_LIST &&
          wd[IDX_LSB +: 5] != 5'h1F && (wd[IDX_LSB +: 5] >= LIST_N || !massOk(arg)))) begin
        rejected_ff <= 1'b1;
      end else if (wrFire && awAddr_ff == ADDR_STATUS && wd[ST_REJ_BIT]) begin
        rejected_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  assign curMass = isMulti_ff ? list_ff[pointIdx_ff[4:0]] : baseMass_ff + pointIdx_ff;
  assign best = (sub_ff == 5'h00 || floatGt(measData, peak_ff)) ? measData : peak_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      isMulti_ff <= 1'b0;
      lastWord_ff <= 1'b0;
      detLatch_ff <= 1'b0;
      rateLatch_ff <= 8'h00;
      baseMass_ff <= 9'h000;
      pointIdx_ff <= 9'h000;
      lastIdx_ff <= 9'h000;
      sub_ff <= 5'h00;
      peak_ff <= 32'h00000000;
      word_ff <= 32'h00000000;
      settle_ff <= 16'h0000;
      offsetDone_ff <= 1'b0;
      measReq_ff <= '0;
      measValid_ff <= 1'b0;
    end else if (ce) begin
      if (scanStart) begin
        isMulti_ff <= (op == OP_MULTI);
        detLatch_ff <= multiplier_ff;
        rateLatch_ff <= rate_ff;
        baseMass_ff <= init_ff;
        pointIdx_ff <= 9'h000;
        lastIdx_ff <= (op == OP_MULTI) ? {4'h0, listCount_ff} - 9'h001 : final_ff - init_ff;
        sub_ff <= 5'h00;
        lastWord_ff <= 1'b0;
        settle_ff <= SETTLE_LOAD;
        measValid_ff <= 1'b0;
        if (autoOfs_ff || !offsetDone_ff) begin
          state_ff <= S_OFFSET;
          measReq_ff <= '{kind: KIND_OFFSET, massStep: 16'h0000,
                          multiplier: multiplier_ff, rate: rate_ff};
          measValid_ff <= 1'b1;
        end else begin
          state_ff <= S_SETTLE;
        end
      end else if (abortScan) begin
        state_ff <= S_IDLE;
        measValid_ff <= 1'b0;
      end else begin
        case (state_ff)
          S_IDLE: state_ff <= S_IDLE;
          S_OFFSET: begin
            if (measDone) begin
              offsetDone_ff <= 1'b1;
              measValid_ff <= 1'b0;
              state_ff <= S_SETTLE;
            end
          end
          S_SETTLE: begin
            if (settle_ff <= 16'h0001) begin
              state_ff <= S_POINT;
            end
            settle_ff <= settle_ff - 16'h0001;
          end
          S_POINT: begin
            measReq_ff.kind <= KIND_ION;
            measReq_ff.massStep <= 16'(curMass) * STEPS_PER_AMU +
                                   (isMulti_ff ? 16'(sub_ff) - MINI_HALF : 16'h0000);
            measReq_ff.multiplier <= detLatch_ff;
            measReq_ff.rate <= rateLatch_ff;
            measValid_ff <= 1'b1;
            state_ff <= S_WAIT;
          end
          S_WAIT: begin
            if (measDone) begin
              measValid_ff <= 1'b0;
              if (isMulti_ff && sub_ff != MINI_LAST) begin
                peak_ff <= best;
                sub_ff <= sub_ff + 5'h01;
                state_ff <= S_POINT;
              end else begin
                word_ff <= best;
                state_ff <= S_SEND;
              end
            end
          end
          S_SEND: begin
            if (wordReady) begin
              sub_ff <= 5'h00;
              if (lastWord_ff) begin
                state_ff <= S_IDLE;
              end else if (pointIdx_ff == lastIdx_ff) begin
                lastWord_ff <= 1'b1;
                if (tpEnable_ff) begin
                  measReq_ff.kind <= KIND_PRESSURE;
                  measValid_ff <= 1'b1;
                  state_ff <= S_PRESS;
                end else begin
                  word_ff <= 32'h00000000;
                end
              end else begin
                pointIdx_ff <= pointIdx_ff + 9'h001;
                state_ff <= S_POINT;
              end
            end
          end
          S_PRESS: begin
            if (measDone) begin
              measValid_ff <= 1'b0;
              word_ff <= measData;
              state_ff <= S_SEND;
            end
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  // Only one word is staged, so the scan paces itself to the host
  mss_byte_serializer u_ser (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .flush(abortScan),
    .wordValid(state_ff == S_SEND),
    .wordData(word_ff),
    .wordReady(wordReady),
    .txData(txData),
    .txValid(txValid),
    .txReady(txReady)
  );

endmodule

`default_nettype wire

// ===== sim/mss_checker.sv
// Port checker of the scan sequencer.
// Assumes the bind below and one clock domain.
`default_nettype none
module mss_checker
  import mss_pkg::*;
#(
  parameter int MAX_MASS = 120
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire mss_meas_req_type measReq,
  input wire logic measReqValid,
  input wire logic measDone,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txReady
);
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n || !ce);
  logic quiet;
  // No write in flight, so no abort can land next edge
  assign quiet = s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid;
  AST_TX_HOLD: assert property (quiet && txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx byte changed before taken");
  AST_REQ_HOLD: assert property (quiet && measReqValid && !measDone |=> $stable(measReq))
    else $error("request changed before done");
  AST_REQ_DROP: assert property (quiet && measDone |=> !measReqValid)
    else $error("request held after done");
  AST_SERIAL: assert property (measReqValid && measReq.kind == KIND_OFFSET |-> !txValid)
    else $error("offset while bytes pending");
  AST_MASS: assert property (measReqValid && measReq.kind == KIND_ION
    |-> measReq.massStep inside {[16'h000E : MAX_MASS * 20 + 6]}) else $error("mass out of range");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cover property (measReqValid && measReq.kind == KIND_ION);
  cover property (measReqValid && measReq.kind == KIND_PRESSURE);
  cover property (txValid && !quiet);
endmodule
bind mass_scan_sequencer mss_checker #(.MAX_MASS(MAX_MASS)) chk_u (.sys_clk, .rst_n, .ce,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .measReq, .measReqValid, .measDone, .txData, .txValid, .txReady);
`default_nettype wire

// ===== sim/mss_host_model.sv
// Host side of the byte stream: collects bytes, may stall.
// Assumes the bench reads and flushes rxBytes.
`default_nettype none
module mss_host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rxBytes[$];
  task automatic flush();
    rxBytes.delete();
  endtask
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txReady <= 1'b0;
    end else begin
      if (txValid && txReady) rxBytes.push_back(txData);
      txReady <= slow ? ~txReady : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Bench of the scan sequencer: AXI master, measurement engine, host.
// Assumes the checker binds itself to the design.
`default_nettype none
module testbench import mss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_n = 0, slow = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0] aw = 0, ar = 0, txData;
  logic [31:0] wd = 0, rdata, measData = 0;
  logic measDone = 0, awr, wr, bv, arr, rv, measReqValid, txValid, txReady;
  logic [1:0] bresp, rresp, lastResp;
  logic [2:0] cnt = 0;
  mss_meas_req_type measReq;
  int n_mismatch = 0, tests_run = 0, cyc = 0, nOfs = 0;
  mass_scan_sequencer #(.SETTLE_CYCLES(2)) dut_u (.sys_clk, .rst_n, .ce(1'b1),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .measReq, .measReqValid, .measDone, .measData, .txData, .txValid,
    .txReady);
  mss_host_model host_u (.sys_clk, .rst_n, .slow, .txData, .txValid, .txReady);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Engine: peak only at the centre step, so the max is known
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      summarize();
    end
    measDone <= 1'b0;
    if (measReqValid && !measDone) begin
      cnt <= cnt + 3'h1;
      if (cnt == 3'h3) begin
        measDone <= 1'b1;
        nOfs <= nOfs + int'(measReq.kind == KIND_OFFSET);
        measData <= measReq.kind == KIND_PRESSURE ? 32'h3F000000 : 32'h40000000 +
          measReq.massStep + (measReq.massStep % 20 == 0 ? 32'h00100000 : 32'h0);
      end
    end else cnt <= 3'h0;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rr <= 1'b0;
    d = rdata;
    lastResp = rresp;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [8:0] arg);
    wr32(ADDR_CMD, {7'h00, arg, 12'h000, op});
  endtask
  task automatic waitIdle();
    logic [31:0] s;
    s = 32'h1;
    while (s[0] || s[3]) rd32(ADDR_STATUS, s);
  endtask
  function automatic logic [31:0] word(input int i);
    return {host_u.rxBytes[4*i+3], host_u.rxBytes[4*i+2], host_u.rxBytes[4*i+1],
      host_u.rxBytes[4*i]};
  endfunction
  task automatic histRun(input int lo, input int hi, input logic [31:0] tp);
    host_u.flush();
    cmd(OP_HIST, 9'h000);
    waitIdle();
    chk(host_u.rxBytes.size(), 4 * (hi - lo + 2));
    for (int m = lo; m <= hi; m++) chk(word(m - lo), 32'h40100000 + 20 * m);
    chk(word(hi - lo + 1), tp);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    rd32(ADDR_FINAL, d);
    chk(d, 32'h41);
    rd32(ADDR_CONFIG, d);
    chk(d, 32'h1005);
    rd32(8'h1C, d);
    chk(lastResp, 2'h2);
  endtask
  task automatic t_limits();
    logic [31:0] d;
    cmd(OP_SET_FINAL, 9'h00A);
    cmd(OP_SET_INIT, 9'h005);
    cmd(OP_SET_INIT, 9'h00B);
    cmd(OP_SET_FINAL, 9'h004);
    cmd(OP_SET_FINAL, 9'h079);
    rd32(ADDR_STATUS, d);
    chk(d[1], 1'b1);
    rd32(ADDR_INIT, d);
    chk(d, 32'h5);
    rd32(ADDR_POINTS, d);
    chk(d, 32'h6);
  endtask
  task automatic t_hist();
    cmd(OP_SET_AUTO, 9'h000);
    slow <= 1'b1;
    histRun(5, 10, 32'h3F000000);
    chk(nOfs, 1);
    cmd(OP_SET_TP, 9'h000);
    histRun(5, 10, 32'h0);
    chk(nOfs, 1);
    cmd(OP_SET_AUTO, 9'h001);
    histRun(5, 10, 32'h0);
    chk(nOfs, 2);
  endtask
  task automatic t_multi();
    wr32(ADDR_LIST, 32'h001C0000);
    wr32(ADDR_LIST, 32'h000E0001);
    wr32(ADDR_LIST, 32'h001C0002);
    wr32(ADDR_LIST, 32'h0003001F);
    host_u.flush();
    cmd(OP_MULTI, 9'h000);
    waitIdle();
    chk(host_u.rxBytes.size(), 16);
    chk(word(0), 32'h40100230);
    chk(word(1), 32'h40100118);
    chk(word(2), 32'h40100230);
  endtask
  task automatic t_abort();
    logic [31:0] d;
    cmd(OP_SET_INIT, 9'h001);
    cmd(OP_SET_FINAL, 9'h064);
    cmd(OP_HIST, 9'h000);
    repeat (60) @(posedge sys_clk);
    cmd(OP_SET_RATE, 9'h020);
    repeat (4) @(posedge sys_clk);
    host_u.flush();
    repeat (20) @(posedge sys_clk);
    chk(host_u.rxBytes.size(), 0);
    rd32(ADDR_STATUS, d);
    chk({d[3], d[0]}, 2'h0);
    cmd(OP_SET_DET, 9'h001);
    rd32(ADDR_CONFIG, d);
    chk(d[15:0], 16'h2003);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_limits();
    t_hist();
    t_multi();
    t_abort();
    summarize();
  end
endmodule
`default_nettype wire
